// File: design/spc_sleep_power_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - mode field bits 3..1: idle, noise, power-down, save, standby, ext standby
// - sleep request enters sleep only while sleep enable bit 0 is one
// - sleep control at 0x33, upper four bits read zero, resets to zero
// - detector sleep set by unlock write then set write within four cycles
// - detector sleep active three cycles after set, cleared three cycles later
// - detector off for a sleep only if sleep taken while detector sleep active
// - power reduction one bit 0 stops timer 3, clear resumes it
// - power reduction zero bit 7 stops two-wire clock; software reinitialises
// - bit 6 stops timer 2 only when timer 2 runs synchronously
// - bits 5 and 3 stop timers 0 and 1, clear resumes them
// - bits 4 and 1 stop serial ports 1 and 0
// - bit 2 stops the spi clock
// - bit 0 shuts the converter; software disables converter first
// - comparator kept off converter mux while converter is shut down
// - input buffers off when io and converter clocks stop, wake pins kept
// - converter stays on in sleep; next conversion after re-power is extended
// - comparator off in deeper sleep unless it uses the internal reference
// - reference on only for detector, comparator reference or converter
// - enabled watchdog keeps running in every sleep mode
// - fused detector stays on in sleep unless detector sleep turned it off
// - enabled debug system keeps main oscillator running; disable bit stops it
// - interrupt wake holds core four cycles beyond start-up time
// - stopped peripheral frozen, its registers not accessible
// - standby modes resume six cycles after wake condition
module spc_sleep_power_control
  import spc_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int STARTUP_CYCLES = 16
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [7:0] rd_data_out,
  input wire logic sleep_req_in,
  input wire logic wake_in,
  input wire logic timer2_async_select_in,
  input wire logic brown_out_level_fuse_in,
  input wire logic debug_enable_fuse_in,
  input wire logic scan_port_enable_fuse_in,
  input wire logic watchdog_enable_in,
  input wire logic converter_enable_in,
  input wire logic comparator_enable_in,
  input wire logic comparator_uses_ref_in,
  input wire logic conversion_start_in,
  input wire logic [NUM_PINS-1:0] wake_pin_mask_in,
  output logic core_halt_out,
  output logic sleeping_out,
  output spc_sleep_s sleep_clk_out,
  output spc_gate_s gate_out,
  output logic [NUM_PINS-1:0] input_buffer_en_out,
  output logic converter_power_out,
  output logic extended_conversion_out,
  output logic comparator_power_out,
  output logic comparator_mux_block_out,
  output logic reference_on_out,
  output logic watchdog_run_out,
  output logic bod_on_out,
  output logic debug_active_out
);

  localparam int WAKE_LONG_CYC = STARTUP_CYCLES + SPC_WAKE_HOLD_CYC;
  localparam int WAKE_W = $clog2(WAKE_LONG_CYC + 1);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [3:0] sleep_ctrl_r;
  logic debug_disable_r;
  logic [2:0] unlock_cnt_r;
  logic [2:0] det_cnt_r;
  logic [7:0] pr_zero_r;
  logic pr_one_r;
  spc_state_e state_r;
  logic [2:0] sleep_mode_r;
  logic det_off_r;
  logic [WAKE_W-1:0] wake_cnt_r;
  logic halt_r;
  logic conv_prev_r;
  logic ext_conv_r;

  logic [2:0] mode_sel;
  logic mode_valid;
  logic det_active;
  logic unlock_open;
  logic wr_mcu;
  logic sleep_take;
  logic deep_sleep;
  logic asleep;
  logic conv_pwr;
  logic cmp_pwr;
  logic dbg_active;
  spc_sleep_s clk_nxt;
  spc_gate_s gate_nxt;

  assign mode_sel = sleep_ctrl_r[SPC_MODE_MSB:SPC_MODE_LSB];
  assign unlock_open = (unlock_cnt_r != 3'h0);
  assign det_active = (det_cnt_r != 3'h0) && (det_cnt_r <= SPC_DET_ACTIVE_CYC);
  assign wr_mcu = wr_strobe_in && (addr_in == SPC_ADDR_MCU_CTRL);

  // reserved selector codes are not valid sleep modes
  always_comb begin
    case (mode_sel)
      SPC_MODE_IDLE, SPC_MODE_NOISE, SPC_MODE_PDOWN,
      SPC_MODE_PSAVE, SPC_MODE_STBY, SPC_MODE_XSTBY: mode_valid = 1'b1;
      default: mode_valid = 1'b0;
    endcase
  end

  // a sleep pulse is honoured only with enable set and a valid mode
  assign sleep_take = sleep_req_in && sleep_ctrl_r[SPC_SE_BIT] && mode_valid
                      && (state_r == SPC_ST_RUN);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // sleep control: only low four bits are storage
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sleep_ctrl_r <= SPC_SLEEP_CTRL_RST;
    end else if (ce_in && wr_strobe_in && addr_in == SPC_ADDR_SLEEP_CTRL) begin
      sleep_ctrl_r <= wr_data_in[3:0];
    end
  end

  // debug disable bit
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      debug_disable_r <= 1'b0;
    end else if (ce_in && wr_mcu) begin
      debug_disable_r <= wr_data_in[SPC_DBG_DIS_BIT];
    end
  end

  // unlock window opened by writing both detector bits to one
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unlock_cnt_r <= 3'h0;
    end else if (ce_in) begin
      if (wr_mcu && wr_data_in[SPC_DET_SLEEP_BIT] && wr_data_in[SPC_DET_UNLOCK_BIT]) begin
        unlock_cnt_r <= SPC_UNLOCK_CYC;
      end else if (unlock_open) begin
        unlock_cnt_r <= unlock_cnt_r - 3'h1;
      end
    end
  end

  // detector sleep: delay phase, active phase, then self clear
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      det_cnt_r <= 3'h0;
    end else if (ce_in) begin
      if (wr_mcu && unlock_open && wr_data_in[SPC_DET_SLEEP_BIT]
          && !wr_data_in[SPC_DET_UNLOCK_BIT]) begin
        det_cnt_r <= SPC_DET_TOTAL_CYC;
      end else if (det_cnt_r != 3'h0) begin
        det_cnt_r <= det_cnt_r - 3'h1;
      end
    end
  end

  // power reduction registers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pr_zero_r <= SPC_PR_RST;
      pr_one_r <= 1'b0;
    end else if (ce_in && wr_strobe_in) begin
      if (addr_in == SPC_ADDR_PR_ZERO) begin
        pr_zero_r <= wr_data_in;
      end
      if (addr_in == SPC_ADDR_PR_ONE) begin
        pr_one_r <= wr_data_in[SPC_PR1_TIMER3_BIT];
      end
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= 8'h00;
    end else if (ce_in) begin
      rd_data_out <= 8'h00;
      if (rd_strobe_in) begin
        case (addr_in)
          SPC_ADDR_SLEEP_CTRL: rd_data_out <= {4'h0, sleep_ctrl_r};
          SPC_ADDR_MCU_CTRL: rd_data_out <= {debug_disable_r, (det_cnt_r != 3'h0),
                                             unlock_open, 5'h00};
          SPC_ADDR_PR_ZERO: rd_data_out <= pr_zero_r;
          SPC_ADDR_PR_ONE: rd_data_out <= {7'h00, pr_one_r};
          SPC_ADDR_STATUS: rd_data_out <= {state_r == SPC_ST_SLEEP, state_r == SPC_ST_WAKE,
                                           det_off_r, det_active, 1'b0, sleep_mode_r};
          default: rd_data_out <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= SPC_ST_RUN;
      sleep_mode_r <= 3'h0;
      det_off_r <= 1'b0;
      wake_cnt_r <= '0;
      halt_r <= 1'b0;
    end else if (ce_in) begin
      case (state_r)
        SPC_ST_RUN: begin
          if (sleep_take) begin
            state_r <= SPC_ST_SLEEP;
            sleep_mode_r <= mode_sel;
            det_off_r <= det_active;
            halt_r <= 1'b1;
          end
        end
        SPC_ST_SLEEP: begin
          if (wake_in) begin
            state_r <= SPC_ST_WAKE;
            det_off_r <= 1'b0;
            if (sleep_mode_r == SPC_MODE_STBY || sleep_mode_r == SPC_MODE_XSTBY) begin
              wake_cnt_r <= WAKE_W'(SPC_STBY_WAKE_CYC);
            end else begin
              wake_cnt_r <= WAKE_W'(WAKE_LONG_CYC);
            end
          end
        end
        SPC_ST_WAKE: begin
          if (wake_cnt_r == WAKE_W'(1)) begin
            state_r <= SPC_ST_RUN;
            halt_r <= 1'b0;
          end else begin
            wake_cnt_r <= wake_cnt_r - WAKE_W'(1);
          end
        end
        default: begin
          state_r <= SPC_ST_RUN;
          halt_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock and power decisions
  // ----------------------------------------------------------------
  assign asleep = (state_r == SPC_ST_SLEEP);
  assign deep_sleep = asleep && (sleep_mode_r != SPC_MODE_IDLE)
                      && (sleep_mode_r != SPC_MODE_NOISE);
  assign dbg_active = debug_enable_fuse_in && scan_port_enable_fuse_in
                      && !debug_disable_r;
  assign conv_pwr = converter_enable_in && !pr_zero_r[SPC_PR0_CONV_BIT];
  assign cmp_pwr = comparator_enable_in && (!deep_sleep || comparator_uses_ref_in);

  // sleep clock domains per mode
  always_comb begin
    clk_nxt.cpu_clk_en = !asleep;
    clk_nxt.io_clk_en = !asleep || sleep_mode_r == SPC_MODE_IDLE;
    clk_nxt.conv_clk_en = !asleep || sleep_mode_r == SPC_MODE_IDLE
                          || sleep_mode_r == SPC_MODE_NOISE;
    clk_nxt.osc_en = !deep_sleep || sleep_mode_r == SPC_MODE_STBY
                     || sleep_mode_r == SPC_MODE_XSTBY || dbg_active;
  end

  // peripheral clock gates; a stopped peripheral is frozen and not accessible
  always_comb begin
    gate_nxt.two_wire = !pr_zero_r[SPC_PR0_TWO_WIRE_BIT];
    gate_nxt.timer2 = !(pr_zero_r[SPC_PR0_TIMER2_BIT] && !timer2_async_select_in);
    gate_nxt.timer0 = !pr_zero_r[SPC_PR0_TIMER0_BIT];
    gate_nxt.serial1 = !pr_zero_r[SPC_PR0_SERIAL1_BIT];
    gate_nxt.timer1 = !pr_zero_r[SPC_PR0_TIMER1_BIT];
    gate_nxt.spi = !pr_zero_r[SPC_PR0_SPI_BIT];
    gate_nxt.serial0 = !pr_zero_r[SPC_PR0_SERIAL0_BIT];
    gate_nxt.converter = !pr_zero_r[SPC_PR0_CONV_BIT];
    gate_nxt.timer3 = !pr_one_r;
  end

  // registered outputs
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sleep_clk_out <= '1;
      gate_out <= '1;
      core_halt_out <= 1'b0;
      sleeping_out <= 1'b0;
      converter_power_out <= 1'b0;
      comparator_power_out <= 1'b0;
      comparator_mux_block_out <= 1'b0;
      reference_on_out <= 1'b0;
      watchdog_run_out <= 1'b0;
      bod_on_out <= 1'b0;
      debug_active_out <= 1'b0;
    end else if (ce_in) begin
      sleep_clk_out <= clk_nxt;
      gate_out <= gate_nxt;
      core_halt_out <= halt_r;
      sleeping_out <= asleep;
      converter_power_out <= conv_pwr;
      comparator_power_out <= cmp_pwr;
      comparator_mux_block_out <= pr_zero_r[SPC_PR0_CONV_BIT];
      reference_on_out <= (brown_out_level_fuse_in && !(asleep && det_off_r))
                          || (cmp_pwr && comparator_uses_ref_in) || conv_pwr;
      watchdog_run_out <= watchdog_enable_in;
      bod_on_out <= brown_out_level_fuse_in && !(asleep && det_off_r);
      debug_active_out <= dbg_active;
    end
  end

  // input buffers per pin, wake pins stay enabled
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          input_buffer_en_out[gi] <= 1'b1;
        end else if (ce_in) begin
          input_buffer_en_out[gi] <= !(deep_sleep && !clk_nxt.io_clk_en
                                       && !clk_nxt.conv_clk_en) || wake_pin_mask_in[gi];
        end
      end
    end
  endgenerate

  // extended conversion flag: set on re-power, cleared by a conversion start
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conv_prev_r <= 1'b0;
      ext_conv_r <= 1'b0;
    end else if (ce_in) begin
      conv_prev_r <= conv_pwr;
      if (conv_pwr && !conv_prev_r) begin
        ext_conv_r <= 1'b1;
      end else if (conversion_start_in) begin
        ext_conv_r <= 1'b0;
      end
    end
  end

  assign extended_conversion_out = ext_conv_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_unlock_wr;
    ce_in && wr_mcu && wr_data_in[SPC_DET_SLEEP_BIT] && wr_data_in[SPC_DET_UNLOCK_BIT];
  endsequence

  sequence s_set_wr;
    ce_in && wr_mcu && wr_data_in[SPC_DET_SLEEP_BIT] && !wr_data_in[SPC_DET_UNLOCK_BIT];
  endsequence

  sequence s_stby_wake;
    ce_in && state_r == SPC_ST_SLEEP && wake_in
    && (sleep_mode_r == SPC_MODE_STBY || sleep_mode_r == SPC_MODE_XSTBY);
  endsequence

  property p_no_enable_no_sleep;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_r == SPC_ST_RUN && !sleep_ctrl_r[SPC_SE_BIT]) |=> state_r == SPC_ST_RUN;
  endproperty
  a_no_enable_no_sleep: assert property (p_no_enable_no_sleep)
    else $error("sleep entered without sleep enable");

  property p_reserved_no_sleep;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_r == SPC_ST_RUN && sleep_req_in && mode_sel[2:1] == 2'b10)
    |=> state_r == SPC_ST_RUN;
  endproperty
  a_reserved_no_sleep: assert property (p_reserved_no_sleep)
    else $error("reserved mode led to sleep");

  property p_sleep_entry;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_r == SPC_ST_RUN && sleep_req_in && sleep_ctrl_r[SPC_SE_BIT] && mode_valid)
    |=> (state_r == SPC_ST_SLEEP && sleep_mode_r == $past(mode_sel)) ##1 (!ce_in || core_halt_out);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("valid sleep request not taken");

  property p_timed_set;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_unlock_wr ##1 (ce_in && !wr_mcu) [*3] ##1 s_set_wr |=> det_cnt_r == SPC_DET_TOTAL_CYC;
  endproperty
  a_timed_set: assert property (p_timed_set)
    else $error("detector sleep not set inside unlock window");

  property p_late_set;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_unlock_wr ##1 (ce_in && !wr_mcu) [*4] ##1 (s_set_wr and (det_cnt_r == 3'h0))
    |=> det_cnt_r == 3'h0;
  endproperty
  a_late_set: assert property (p_late_set)
    else $error("detector sleep set after unlock window");

  property p_active_delay;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (det_cnt_r == SPC_DET_TOTAL_CYC && ce_in && !det_active) ##1 (ce_in && !det_active) [*2]
    |=> det_active ##1 (!ce_in || det_active) ##1 (!ce_in || det_active);
  endproperty
  a_active_delay: assert property (p_active_delay)
    else $error("detector sleep activation timing wrong");

  property p_self_clear;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && det_cnt_r == 3'h1 && !wr_mcu) |=> !det_active && det_cnt_r == 3'h0;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("detector sleep not cleared");

  property p_stby_wake;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_stby_wake ##1 ce_in [*6] |=> state_r == SPC_ST_RUN && !halt_r;
  endproperty
  a_stby_wake: assert property (p_stby_wake)
    else $error("standby wake not six cycles");

  property p_timer2_gate;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && pr_zero_r[SPC_PR0_TIMER2_BIT] && !timer2_async_select_in) |=> !gate_out.timer2;
  endproperty
  a_timer2_gate: assert property (p_timer2_gate)
    else $error("timer 2 clock not stopped");

  property p_mux_block;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && pr_zero_r[SPC_PR0_CONV_BIT]) |=> comparator_mux_block_out && !converter_power_out;
  endproperty
  a_mux_block: assert property (p_mux_block)
    else $error("comparator may use converter mux");

  property p_bod_off;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && asleep && det_off_r) |=> !bod_on_out;
  endproperty
  a_bod_off: assert property (p_bod_off)
    else $error("detector still on after detector sleep");

endmodule

// File: design/spc_pkg.sv
package spc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPC_ADDR_SLEEP_CTRL = 8'h33;
  localparam logic [7:0] SPC_ADDR_MCU_CTRL = 8'h34;
  localparam logic [7:0] SPC_ADDR_PR_ZERO = 8'h35;
  localparam logic [7:0] SPC_ADDR_PR_ONE = 8'h36;
  localparam logic [7:0] SPC_ADDR_STATUS = 8'h37;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SPC_SE_BIT = 0;
  localparam int SPC_MODE_LSB = 1;
  localparam int SPC_MODE_MSB = 3;
  localparam int SPC_DBG_DIS_BIT = 7;
  localparam int SPC_DET_SLEEP_BIT = 6;
  localparam int SPC_DET_UNLOCK_BIT = 5;
  localparam int SPC_PR0_TWO_WIRE_BIT = 7;
  localparam int SPC_PR0_TIMER2_BIT = 6;
  localparam int SPC_PR0_TIMER0_BIT = 5;
  localparam int SPC_PR0_SERIAL1_BIT = 4;
  localparam int SPC_PR0_TIMER1_BIT = 3;
  localparam int SPC_PR0_SPI_BIT = 2;
  localparam int SPC_PR0_SERIAL0_BIT = 1;
  localparam int SPC_PR0_CONV_BIT = 0;
  localparam int SPC_PR1_TIMER3_BIT = 0;
  localparam logic [3:0] SPC_SLEEP_CTRL_RST = 4'h0;
  localparam logic [7:0] SPC_PR_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing counts in clock cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] SPC_UNLOCK_CYC = 3'h4;
  localparam logic [2:0] SPC_DET_DELAY_CYC = 3'h3;
  localparam logic [2:0] SPC_DET_ACTIVE_CYC = 3'h3;
  localparam logic [2:0] SPC_DET_TOTAL_CYC = 3'(SPC_DET_DELAY_CYC + SPC_DET_ACTIVE_CYC);
  localparam int SPC_STBY_WAKE_CYC = 6;
  localparam int SPC_WAKE_HOLD_CYC = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPC_MODE_IDLE = 3'h0,
    SPC_MODE_NOISE = 3'h1,
    SPC_MODE_PDOWN = 3'h2,
    SPC_MODE_PSAVE = 3'h3,
    SPC_MODE_STBY = 3'h6,
    SPC_MODE_XSTBY = 3'h7
  } spc_mode_e;

  typedef enum logic [2:0] {
    SPC_ST_RUN = 3'b001,
    SPC_ST_SLEEP = 3'b010,
    SPC_ST_WAKE = 3'b100
  } spc_state_e;

  typedef struct packed {
    logic two_wire;
    logic timer2;
    logic timer0;
    logic serial1;
    logic timer1;
    logic spi;
    logic serial0;
    logic converter;
    logic timer3;
  } spc_gate_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic io_clk_en;
    logic conv_clk_en;
    logic osc_en;
  } spc_sleep_s;

endpackage

// File: testbench/spc_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core side: register writes, reads, sleep
// ----------------------------------------
module spc_core_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic sleep_out,
  input wire logic [7:0] rd_data_in
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    sleep_out = 1'b0;
  end
  // one write cycle, taken at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    rd_out <= 1'b0;
    sleep_out <= 1'b0;
    @(posedge clk_in);
  endtask
  // one read cycle, data taken in the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_out <= a;
    wr_out <= 1'b0;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 d = rd_data_in;
  endtask
  // one-cycle sleep pulse, also sent while enable is clear
  task automatic slp();
    sleep_out <= 1'b1;
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic idle();
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    sleep_out <= 1'b0;
  endtask
endmodule

// File: testbench/spc_sleep_power_control_bench.sv
`timescale 1ns/1ps
module spc_sleep_power_control_bench;
  import spc_pkg::*;
  localparam int SU = 5;
  logic clk = 1'b0, rstn = 1'b0, wake = 1'b0, async = 1'b0, fuse = 1'b0;
  logic dbg_f = 1'b1, scan_f = 1'b1, wdog = 1'b1, conv = 1'b1, comp = 1'b1;
  logic cref = 1'b0, cstart = 1'b0, halt, slpg, cext, cpow, mblk, refo, wrun, brown_out_detector, dbg;
  logic wr, rd, sreq, convp;
  logic [7:0] addr, wdata, rdata, d, mask = 8'hA5, ibuf;
  spc_sleep_s sclk;
  spc_gate_s gate;
  int fails = 0, num_checks = 0, n;
  spc_sleep_power_control #(.NUM_PINS(8), .STARTUP_CYCLES(SU)) spc_sleep_power_control_inst (
    .core_clk_in(clk), .resetn_in(rstn), .ce_in(1'b1), .addr_in(addr),
    .wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata),
    .sleep_req_in(sreq), .wake_in(wake), .timer2_async_select_in(async),
    .brown_out_level_fuse_in(fuse), .debug_enable_fuse_in(dbg_f),
    .scan_port_enable_fuse_in(scan_f), .watchdog_enable_in(wdog),
    .converter_enable_in(conv), .comparator_enable_in(comp),
    .comparator_uses_ref_in(cref), .conversion_start_in(cstart),
    .wake_pin_mask_in(mask), .core_halt_out(halt), .sleeping_out(slpg),
    .sleep_clk_out(sclk), .gate_out(gate), .input_buffer_en_out(ibuf),
    .converter_power_out(convp), .extended_conversion_out(cext),
    .comparator_power_out(cpow), .comparator_mux_block_out(mblk),
    .reference_on_out(refo), .watchdog_run_out(wrun), .bod_on_out(brown_out_detector),
    .debug_active_out(dbg));
  spc_core_model spc_core_model_inst (.clk_in(clk), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .sleep_out(sreq), .rd_data_in(rdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    spc_core_model_inst.rd(a, d);
    check(d, e);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    spc_core_model_inst.wr(a, v);
    spc_core_model_inst.idle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic nap();
    spc_core_model_inst.slp();
    spc_core_model_inst.idle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // wake pulse, then count cycles until the core is released
  task automatic wake_wait(output int cnt);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    cnt = 1;
    while (halt === 1'b1 && cnt < 60) begin
      @(posedge clk);
      #1 cnt++;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk(SPC_ADDR_SLEEP_CTRL, 8'h00);
    check(gate, 9'h1FF);
    put(SPC_ADDR_SLEEP_CTRL, 8'hFF);
    rdchk(SPC_ADDR_SLEEP_CTRL, 8'h0F);
    rdchk(8'h40, 8'h00);
    put(SPC_ADDR_SLEEP_CTRL, 8'h00);
    $display("done regs");
  endtask
  task automatic t_gates();
    for (int k = 0; k < 8; k++) begin
      put(SPC_ADDR_PR_ZERO, 8'h01 << k);
      check(gate, 9'h1FF ^ (9'h002 << k));
      check(mblk, k == 0);
    end
    async <= 1'b1;
    put(SPC_ADDR_PR_ZERO, 8'h40);
    check(gate, 9'h1FF);
    async <= 1'b0;
    put(SPC_ADDR_PR_ZERO, 8'h00);
    put(SPC_ADDR_PR_ONE, 8'hFF);
    check(gate, 9'h1FE);
    rdchk(SPC_ADDR_PR_ONE, 8'h01);
    put(SPC_ADDR_PR_ONE, 8'h00);
    check(gate, 9'h1FF);
    $display("done gates");
  endtask
  task automatic t_sleep();
    logic [2:0] m;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    put(SPC_ADDR_SLEEP_CTRL, 8'h04);
    nap();
    check(slpg, 1'b0);
    for (int r = 4; r < 6; r++) begin
      put(SPC_ADDR_SLEEP_CTRL, 8'(r * 2 + 1));
      nap();
      check(slpg, 1'b0);
    end
    foreach (codes[i]) begin
      m = codes[i];
      put(SPC_ADDR_SLEEP_CTRL, {4'h0, m, 1'b1});
      nap();
      check({slpg, halt}, 9'h003);
      check(ibuf, (m >= 3'h2) ? mask : 8'hFF);
      check(cpow, m < 3'h2);
      check({wrun, convp}, 9'h003);
      check(sclk, {6'h00, m == 3'h0, m < 3'h2, 1'b1});
      wake_wait(n);
      if (m >= 3'h6) check(n, 9'(SPC_STBY_WAKE_CYC + 2));
      else check(n, 9'(SU + SPC_WAKE_HOLD_CYC + 2));
      put(SPC_ADDR_SLEEP_CTRL, 8'h00);
    end
    $display("done sleep");
  endtask
  task automatic t_det();
    fuse <= 1'b1;
    put(SPC_ADDR_SLEEP_CTRL, 8'h05);
    spc_core_model_inst.wr(SPC_ADDR_MCU_CTRL, 8'h60);
    spc_core_model_inst.idle();
    repeat (3) @(posedge clk);
    spc_core_model_inst.wr(SPC_ADDR_MCU_CTRL, 8'h40);
    spc_core_model_inst.idle();
    repeat (3) @(posedge clk);
    nap();
    check({slpg, brown_out_detector}, 9'h002);
    wake_wait(n);
    repeat (2) @(posedge clk);
    #1 check(brown_out_detector, 1'b1);
    put(SPC_ADDR_MCU_CTRL, 8'h60);
    repeat (2) @(posedge clk);
    put(SPC_ADDR_MCU_CTRL, 8'h40);
    repeat (6) @(posedge clk);
    nap();
    check({slpg, brown_out_detector}, 9'h003);
    wake_wait(n);
    put(SPC_ADDR_SLEEP_CTRL, 8'h00);
    $display("done detector");
  endtask
  task automatic t_misc();
    check(dbg, 1'b1);
    put(SPC_ADDR_MCU_CTRL, 8'h80);
    check(dbg, 1'b0);
    put(SPC_ADDR_MCU_CTRL, 8'h00);
    fuse <= 1'b0;
    conv <= 1'b0;
    comp <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(refo, 1'b0);
    conv <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({refo, cext}, 9'h003);
    cstart <= 1'b1;
    @(posedge clk);
    cstart <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(cext, 1'b0);
    $display("done misc");
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #40000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_gates();
    t_sleep();
    t_det();
    t_misc();
    stop_test();
  end
endmodule
